// *** hw/stfd_top.sv ***
// Purpose: self-test secondary check and fault display control
// Assumes: wishbone classic slave, one clock, synchronous reset
// Notes: reset value of sync stages loaded via rst path in top
`timescale 1ns/1ps

module stfd_top
	import stfd_pkg::*;
#(
	parameter int MUX_ERR_W = 4,
	parameter int DEMUX_ERR_W = 4,
	parameter int SEL_W = 7
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// diagnostic inputs, high means no error on mux_ok_i, tol_ok_i, demux_ok_i and overtemp_n_i, while high on sel_err_i bits 2 to 6 flags an error in self-test
	input wire logic [MUX_ERR_W-1:0] mux_ok_i,
	input wire logic tol_ok_i,
	input wire logic [DEMUX_ERR_W-1:0] demux_ok_i,
	input wire logic [SEL_W-1:0] sel_err_i,
	input wire logic word_scan_end_i,
	input wire logic overtemp_n_i,
	input wire logic overtemp_shutdown_strap_i,
	// display card codes
	input wire logic [1:0] tens_code_i,
	input wire logic [3:0] units_code_i,
	// fault display and indicators
	output logic [1:0] tens_digit_o,
	output logic [3:0] units_digit_o,
	output logic ripple_blank_in_n_o,
	output logic lamp_dec_en_o,
	output logic mux_card_error_o,
	output logic temp_lamp_o,
	output logic supply_inhibit_o,
	output logic temp_alarm_clear_o,
	// alarm distribution card
	output logic self_check_request_o,
	output logic self_test_active_n_o,
	output logic mux_error_reset_o,
	output logic demux_error_reset_o,
	output logic mux_no_err_o,
	output logic demux_no_err_o,
	output logic sec_err_o,
	// interrupt
	output logic irq_o
);
	localparam int SYNC_W = MUX_ERR_W + DEMUX_ERR_W + SEL_W + 3;

	if (SEL_W <= STFD_SEL_HI) begin : g_bad_sel_w
		$error("stfd_top needs selector outputs up to 6");
	end

	// ************************************************************
	// input synchronisation
	// ************************************************************
	logic [SYNC_W-1:0] raw;
	logic [SYNC_W-1:0] synced;
	logic [MUX_ERR_W-1:0] mux_ok;
	logic [DEMUX_ERR_W-1:0] demux_ok;
	logic [SEL_W-1:0] sel_err;
	logic tol_ok;
	logic scan_end;
	logic hot;
	logic reset_done;

	assign raw = {mux_ok_i, demux_ok_i, sel_err_i, tol_ok_i,
		word_scan_end_i, overtemp_n_i};

	stfd_sync #(.W(SYNC_W)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(raw),
		.init_i({SYNC_W{1'b0}}),
		.q_o(synced)
	);

	// hold off evaluation until the sync pipe has flushed after reset
	logic [1:0] flush;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flush <= 2'h0;
		end else if (!reset_done) begin
			flush <= flush + 2'h1;
		end
	end
	assign reset_done = (flush == 2'h3);

	assign mux_ok = reset_done ? synced[SYNC_W-1 -: MUX_ERR_W]
		: {MUX_ERR_W{1'b1}};
	assign demux_ok = reset_done
		? synced[SEL_W+3 +: DEMUX_ERR_W] : {DEMUX_ERR_W{1'b1}};
	assign sel_err = reset_done ? synced[3 +: SEL_W] : {SEL_W{1'b0}};
	assign tol_ok = reset_done ? synced[2] : 1'b1;
	assign scan_end = reset_done ? synced[1] : 1'b0;
	assign hot = reset_done ? !synced[0] : 1'b0;

	// ************************************************************
	// control register
	// ************************************************************
	logic [3:0] ctrl;
	logic [STFD_EV_W-1:0] irq_stat;
	logic [STFD_EV_W-1:0] irq_mask;
	logic wb_req;
	logic wb_wr;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_mask;
	logic [31:0] rd_data;

	assign wb_req = cyc_i && stb_i && !ack_o;
	assign wb_wr = wb_req && we_i && sel_i[0];
	assign wr_ctrl = wb_wr && (adr_i == STFD_OFS_CTRL);
	assign wr_stat = wb_wr && (adr_i == STFD_OFS_IRQ_STAT);
	assign wr_mask = wb_wr && (adr_i == STFD_OFS_IRQ_MASK);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= STFD_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl <= dat_i[3:0];
		end
	end

	logic self_test;
	logic lamp_test;
	logic disp_reset;
	logic pwr_on;
	assign self_test = ctrl[STFD_CTRL_SELF_TEST];
	assign lamp_test = ctrl[STFD_CTRL_LAMP_TEST];
	assign disp_reset = ctrl[STFD_CTRL_DISP_RESET];
	assign pwr_on = ctrl[STFD_CTRL_PWR_ON];

	// ************************************************************
	// switch edges and error resets
	// ************************************************************
	logic st_d;
	logic lt_d;
	logic dr_d;
	logic pw_d;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_d <= 1'b0;
			lt_d <= 1'b0;
			dr_d <= 1'b0;
			pw_d <= 1'b1;
		end else begin
			st_d <= self_test;
			lt_d <= lamp_test;
			dr_d <= disp_reset;
			pw_d <= pwr_on;
		end
	end

	logic st_fall;
	logic lt_fall;
	logic dr_rise;
	logic pw_fall;
	assign st_fall = st_d && !self_test;
	assign lt_fall = lt_d && !lamp_test;
	assign dr_rise = disp_reset && !dr_d;
	assign pw_fall = pw_d && !pwr_on;

	logic err_reset;
	assign err_reset = st_fall || dr_rise;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mux_error_reset_o <= 1'b0;
			demux_error_reset_o <= 1'b0;
		end else begin
			mux_error_reset_o <= err_reset;
			demux_error_reset_o <= err_reset;
		end
	end

	assign self_check_request_o = self_test;
	assign self_test_active_n_o = !self_test;

	// ************************************************************
	// self-test delay: third scan end arms the decoder
	// ************************************************************
	stfd_st_t state;
	stfd_st_t next_state;
	logic [1:0] scan_cnt;
	logic scan_d;
	logic scan_pulse;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scan_d <= 1'b0;
		end else begin
			scan_d <= scan_end;
		end
	end
	assign scan_pulse = scan_end && !scan_d;

	always_comb begin
		next_state = state;
		case (state)
			STFD_IDLE: begin
				if (self_test) begin
					next_state = STFD_WAIT;
				end
			end
			STFD_WAIT: begin
				if (!self_test) begin
					next_state = STFD_IDLE;
				end else if (scan_pulse &&
					scan_cnt == 2'(STFD_SCAN_ENDS - 1)) begin
					next_state = STFD_ARMED;
				end
			end
			STFD_ARMED: begin
				if (!self_test) begin
					next_state = STFD_IDLE;
				end
			end
			default: begin
				next_state = STFD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= STFD_IDLE;
			scan_cnt <= 2'h0;
		end else begin
			state <= next_state;
			if (state != STFD_WAIT) begin
				scan_cnt <= 2'h0;
			end else if (scan_pulse) begin
				scan_cnt <= scan_cnt + 2'h1;
			end
		end
	end

	// ************************************************************
	// secondary diagnostic check
	// ************************************************************
	logic mux_no_err;
	logic demux_no_err;
	logic sel_any;
	logic sec_err;
	assign mux_no_err = (&mux_ok) && tol_ok;
	assign demux_no_err = &demux_ok;
	assign sel_any = |sel_err[STFD_SEL_HI:STFD_SEL_LO];
	assign sec_err = sel_any && self_test;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mux_no_err_o <= 1'b0;
			demux_no_err_o <= 1'b0;
			sec_err_o <= 1'b0;
			mux_card_error_o <= 1'b0;
			lamp_dec_en_o <= 1'b0;
		end else begin
			mux_no_err_o <= mux_no_err;
			demux_no_err_o <= demux_no_err;
			sec_err_o <= sec_err;
			mux_card_error_o <= sec_err;
			// armed decode, forced on by a secondary error or lamp test
			lamp_dec_en_o <= (state == STFD_ARMED) || sec_err
				|| lamp_test;
		end
	end

	// ************************************************************
	// fault location display
	// ************************************************************
	logic [1:0] next_tens;
	logic [3:0] next_units;
	always_comb begin
		if (lamp_test) begin
			next_tens = STFD_TENS_EIGHT;
			next_units = STFD_UNITS_EIGHT;
		end else if (sec_err) begin
			next_tens = STFD_TENS_TWO;
			next_units = STFD_UNITS_TWO;
		end else if (self_test) begin
			next_tens = 2'h0;
			next_units = 4'h0;
		end else begin
			next_tens = tens_code_i;
			next_units = units_code_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tens_digit_o <= 2'h0;
			units_digit_o <= 4'h0;
			ripple_blank_in_n_o <= 1'b1;
		end else begin
			tens_digit_o <= next_tens;
			units_digit_o <= next_units;
			ripple_blank_in_n_o <= !(self_test && !sec_err
				&& !lamp_test);
		end
	end

	// ************************************************************
	// temperature alarm latch and supply inhibit
	// ************************************************************
	logic temp_latch;
	logic alarm_clear;
	assign alarm_clear = st_fall || lt_fall;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			temp_latch <= 1'b0;
			supply_inhibit_o <= 1'b0;
			temp_alarm_clear_o <= 1'b0;
		end else begin
			temp_alarm_clear_o <= alarm_clear;
			// a set in the clearing cycle wins
			if (hot || self_test) begin
				temp_latch <= 1'b1;
			end else if (alarm_clear) begin
				temp_latch <= 1'b0;
			end
			// inhibit holds until power control cycles off
			if (hot && overtemp_shutdown_strap_i) begin
				supply_inhibit_o <= 1'b1;
			end else if (pw_fall) begin
				supply_inhibit_o <= 1'b0;
			end
		end
	end
	assign temp_lamp_o = temp_latch || lamp_test;

	// ************************************************************
	// interrupts and register read
	// ************************************************************
	logic [STFD_EV_W-1:0] ev;
	assign ev = {st_fall, hot, sec_err};

	genvar gi;
	generate
		for (gi = 0; gi < STFD_EV_W; gi++) begin : g_irq
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					irq_stat[gi] <= STFD_EV_RESET[gi];
				end else if (ev[gi]) begin
					irq_stat[gi] <= 1'b1;
				end else if (wr_stat && dat_i[gi]) begin
					irq_stat[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_mask <= STFD_MASK_RESET;
		end else if (wr_mask) begin
			irq_mask <= dat_i[STFD_EV_W-1:0];
		end
	end
	assign irq_o = |(irq_stat & irq_mask);

	logic [31:0] stat_word;
	assign stat_word = {22'h0, temp_latch, supply_inhibit_o,
		lamp_dec_en_o, sec_err_o, demux_no_err_o, mux_no_err_o,
		state, 2'h0};

	always_comb begin
		case (adr_i)
			STFD_OFS_CTRL: rd_data = {28'h0, ctrl};
			STFD_OFS_STAT: rd_data = stat_word;
			STFD_OFS_IRQ_STAT: rd_data = {29'h0, irq_stat};
			STFD_OFS_IRQ_MASK: rd_data = {29'h0, irq_mask};
			default: rd_data = 32'h0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end else begin
			ack_o <= wb_req;
			dat_o <= (wb_req && !we_i) ? rd_data : 32'h0;
		end
	end
endmodule : stfd_top

// *** pkg/stfd_pkg.sv ***
// Purpose: shared constants for the self-test fault display block
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: wishbone register map, field positions and reset values
package stfd_pkg;

	// ************************************************************
	// register map (byte addresses)
	// ************************************************************
	localparam logic [3:0] STFD_OFS_CTRL = 4'h0;
	localparam logic [3:0] STFD_OFS_STAT = 4'h4;
	localparam logic [3:0] STFD_OFS_IRQ_STAT = 4'h8;
	localparam logic [3:0] STFD_OFS_IRQ_MASK = 4'hC;

	// ************************************************************
	// control fields
	// ************************************************************
	localparam int STFD_CTRL_SELF_TEST = 0;
	localparam int STFD_CTRL_LAMP_TEST = 1;
	localparam int STFD_CTRL_DISP_RESET = 2;
	localparam int STFD_CTRL_PWR_ON = 3;
	localparam logic [3:0] STFD_CTRL_RESET = 4'h8;

	// ************************************************************
	// status / interrupt fields
	// ************************************************************
	localparam int STFD_EV_SEC_ERR = 0;
	localparam int STFD_EV_OVERTEMP = 1;
	localparam int STFD_EV_ST_EXIT = 2;
	localparam int STFD_EV_W = 3;
	localparam logic [2:0] STFD_EV_RESET = 3'h0;
	localparam logic [2:0] STFD_MASK_RESET = 3'h0;

	// ************************************************************
	// display codes and counts
	// ************************************************************
	localparam logic [1:0] STFD_TENS_TWO = 2'h2;
	localparam logic [3:0] STFD_UNITS_TWO = 4'h2;
	localparam logic [1:0] STFD_TENS_EIGHT = 2'h2;
	localparam logic [3:0] STFD_UNITS_EIGHT = 4'h8;
	localparam int STFD_SCAN_ENDS = 3;
	localparam int STFD_SEL_LO = 2;
	localparam int STFD_SEL_HI = 6;
	localparam int STFD_SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		STFD_IDLE = 2'b00,
		STFD_WAIT = 2'b01,
		STFD_ARMED = 2'b11
	} stfd_st_t;

endpackage : stfd_pkg

// *** hw/stfd_sync.sv ***
// Purpose: two-stage synchroniser for a vector of levels
// Assumes: inputs are static levels relative to clk_i
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module stfd_sync #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// data
	input wire logic [W-1:0] d_i,
	input wire logic [W-1:0] init_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta;

	if (W < 1) begin : g_bad_width
		$error("stfd_sync width must be positive");
	end

	// reset loads a known level so nothing downstream sees unknowns
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta <= init_i;
			q_o <= init_i;
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule : stfd_sync

// *** dv/stfd_checker.sv ***
// Purpose: port-level checks of the fault display block
// Assumes: one clock, synchronous active-high reset
// Notes: sees a subset of the top module ports only
`timescale 1ns/1ps
module stfd_checker
	import stfd_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// watched ports
	input wire logic ack_o,
	input wire logic sec_err_o,
	input wire logic mux_card_error_o,
	input wire logic lamp_dec_en_o,
	input wire logic [1:0] tens_digit_o,
	input wire logic [3:0] units_digit_o,
	input wire logic ripple_blank_in_n_o,
	input wire logic self_test_active_n_o,
	input wire logic self_check_request_o,
	input wire logic temp_lamp_o,
	input wire logic supply_inhibit_o,
	input wire logic overtemp_shutdown_strap_i,
	input wire logic mux_error_reset_o,
	input wire logic demux_error_reset_o,
	input wire logic temp_alarm_clear_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack held too long");
	a_req_pair: assert property (
		self_check_request_o != self_test_active_n_o)
		else $error("request and self-test level disagree");
	a_card_err: assert property (mux_card_error_o == sec_err_o)
		else $error("card error missing");
	a_dec_on_err: assert property (sec_err_o |-> ##[0:1] lamp_dec_en_o)
		else $error("decoder enable missing");
	a_err_needs_st: assert property ($rose(sec_err_o) |->
		!self_test_active_n_o)
		else $error("secondary error outside self-test");
	a_code_22: assert property ($rose(sec_err_o) |-> ##[0:2]
		(tens_digit_o == STFD_TENS_TWO
		&& units_digit_o == STFD_UNITS_TWO))
		else $error("fault code not 22");
	a_blank_in_st: assert property ($fell(ripple_blank_in_n_o) |->
		!self_test_active_n_o)
		else $error("blanking outside self-test");
	a_st_lamp: assert property ($fell(self_test_active_n_o) |->
		##[1:4] temp_lamp_o)
		else $error("temperature lamp not lit");
	a_strap_gate: assert property ($rose(supply_inhibit_o) |->
		$past(overtemp_shutdown_strap_i))
		else $error("inhibit without strap");
	a_resets_pair: assert property (
		mux_error_reset_o == demux_error_reset_o)
		else $error("error resets apart");
	a_exit_reset: assert property ($rose(self_test_active_n_o) |->
		##[0:3] (mux_error_reset_o && temp_alarm_clear_o))
		else $error("no reset at self-test exit");
endmodule : stfd_checker

bind stfd_top stfd_checker stfd_checker_inst (.*);

// *** dv/stfd_panel.sv ***
// Purpose: behavioural front panel fed by the block
// Assumes: each digit code is plain binary
// Notes: blanking shows 00 on both digits
`timescale 1ns/1ps
module stfd_panel (
	// from the block
	input wire logic [1:0] tens_i,
	input wire logic [3:0] units_i,
	input wire logic blank_n_i,
	input wire logic inhibit_i,
	// what the operator sees
	output logic [7:0] shown_o,
	output logic power_o
);
	// blanking wins over the codes
	assign shown_o = blank_n_i ? {2'h0, tens_i, units_i} : 8'h00;
	// supply stays off while inhibited
	assign power_o = !inhibit_i;
endmodule : stfd_panel

// *** dv/stfd_top_tb.sv ***
// Purpose: directed bench for the fault display block
// Assumes: classic wishbone master, 100 MHz clock
// Notes: one task per scenario
`timescale 1ns/1ps
module stfd_top_tb
	import stfd_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
	logic [3:0] adr_i = 4'h0, sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	logic [3:0] mux_ok_i = 4'hF, demux_ok_i = 4'hF;
	logic tol_ok_i = 1'b1, word_scan_end_i = 1'b0, overtemp_n_i = 1'b1;
	logic overtemp_shutdown_strap_i = 1'b0;
	logic [6:0] sel_err_i = 7'h00;
	logic [1:0] tens_code_i = 2'h1, tens_digit_o;
	logic [3:0] units_code_i = 4'h9, units_digit_o;
	logic ripple_blank_in_n_o, lamp_dec_en_o, mux_card_error_o, temp_lamp_o;
	logic supply_inhibit_o, temp_alarm_clear_o, self_check_request_o;
	logic self_test_active_n_o, mux_error_reset_o, demux_error_reset_o;
	logic mux_no_err_o, demux_no_err_o, sec_err_o, irq_o, power;
	logic [7:0] shown;
	logic [2:0] seen;
	int failures = 0, compares = 0, cycles = 0;

	always #5 clk_i = ~clk_i;

	stfd_top stfd_top_inst (.*);
	stfd_panel stfd_panel_inst (.tens_i(tens_digit_o), .units_i(units_digit_o),
		.blank_n_i(ripple_blank_in_n_o), .inhibit_i(supply_inhibit_o),
		.shown_o(shown), .power_o(power));

	// ************************************************************
	// helpers
	// ************************************************************
	task tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick

	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: %h, expected %h", $time, g, e);
		end
	endtask : chk

	// classic cycle, held until ack is sampled
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		// ack, or else the hang guard, ends this wait
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : wb

	task watch;
		seen = 3'h0;
		repeat (8) begin
			@(posedge clk_i);
			seen = seen | {temp_alarm_clear_o, demux_error_reset_o,
				mux_error_reset_o};
		end
	endtask : watch

	task give_verdict;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : give_verdict

	// ************************************************************
	// scenarios
	// ************************************************************
	task t_regs;
		wb(1'b0, STFD_OFS_CTRL, 32'h0);
		chk(rd, {28'h0, STFD_CTRL_RESET});
		wb(1'b0, STFD_OFS_IRQ_MASK, 32'h0);
		chk(rd, 32'h0);
		wb(1'b0, STFD_OFS_STAT, 32'h0);
		chk(rd, 32'h30);
		// a write without byte lane 0 must be ignored
		sel_i <= 4'h0;
		wb(1'b1, STFD_OFS_IRQ_MASK, 32'h7);
		sel_i <= 4'hF;
		wb(1'b0, STFD_OFS_IRQ_MASK, 32'h0);
		chk(rd, 32'h0);
		wb(1'b1, 4'h2, 32'hFFFF_FFFF);
		wb(1'b0, 4'h2, 32'h0);
		chk(rd, 32'h0);
		chk(shown, 8'h19);
		$display("registers done");
	endtask : t_regs

	task t_sums;
		for (int i = 0; i < 4; i++) begin
			mux_ok_i <= 4'hF ^ (4'h1 << i);
			demux_ok_i <= 4'hF ^ (4'h1 << i);
			tick(5);
			chk(mux_no_err_o, 1'b0);
			chk(demux_no_err_o, 1'b0);
		end
		mux_ok_i <= 4'hF;
		demux_ok_i <= 4'hF;
		tol_ok_i <= 1'b0;
		tick(5);
		chk(mux_no_err_o, 1'b0);
		tol_ok_i <= 1'b1;
		tick(5);
		chk({mux_no_err_o, demux_no_err_o}, 2'h3);
		$display("summaries done");
	endtask : t_sums

	task t_self;
		wb(1'b1, STFD_OFS_IRQ_MASK, 32'h1);
		wb(1'b1, STFD_OFS_CTRL, 32'h9);
		tick(4);
		chk(self_check_request_o, 1'b1);
		chk(shown, 8'h00);
		chk(temp_lamp_o, 1'b1);
		for (int i = 1; i <= 3; i++) begin
			word_scan_end_i <= 1'b1;
			tick(2);
			word_scan_end_i <= 1'b0;
			tick(5);
			chk(lamp_dec_en_o, i == 3);
		end
		sel_err_i <= 7'h03;
		tick(5);
		chk(sec_err_o, 1'b0);
		for (int i = 2; i <= 6; i++) begin
			sel_err_i <= 7'h01 << i;
			tick(5);
			chk(sec_err_o, 1'b1);
			chk(mux_card_error_o, 1'b1);
			chk({tens_digit_o, units_digit_o},
				{STFD_TENS_TWO, STFD_UNITS_TWO});
			sel_err_i <= 7'h00;
			tick(5);
			chk(sec_err_o, 1'b0);
		end
		chk(irq_o, 1'b1);
		wb(1'b0, STFD_OFS_IRQ_STAT, 32'h0);
		chk(rd, 32'h1);
		wb(1'b1, STFD_OFS_IRQ_STAT, 32'h1);
		chk(irq_o, 1'b0);
		wb(1'b1, STFD_OFS_CTRL, 32'h8);
		watch;
		chk(seen, 3'h7);
		sel_err_i <= 7'h40;
		tick(5);
		chk(sec_err_o, 1'b0);
		sel_err_i <= 7'h00;
		wb(1'b0, STFD_OFS_IRQ_STAT, 32'h0);
		chk(rd, 32'h4);
		wb(1'b1, STFD_OFS_IRQ_STAT, 32'h7);
		wb(1'b1, STFD_OFS_IRQ_MASK, 32'h0);
		$display("self-test done");
	endtask : t_self

	task t_lamp;
		wb(1'b1, STFD_OFS_CTRL, 32'hC);
		watch;
		chk(seen, 3'h3);
		wb(1'b1, STFD_OFS_CTRL, 32'hA);
		tick(3);
		chk({tens_digit_o, units_digit_o},
			{STFD_TENS_EIGHT, STFD_UNITS_EIGHT});
		chk(temp_lamp_o, 1'b1);
		wb(1'b1, STFD_OFS_CTRL, 32'h8);
		watch;
		chk(seen[2], 1'b1);
		chk({temp_lamp_o, shown}, 9'h019);
		$display("lamp test done");
	endtask : t_lamp

	task t_hot;
		overtemp_n_i <= 1'b0;
		tick(6);
		chk({temp_lamp_o, supply_inhibit_o, irq_o}, 3'h4);
		overtemp_n_i <= 1'b1;
		wb(1'b1, STFD_OFS_CTRL, 32'hA);
		wb(1'b1, STFD_OFS_CTRL, 32'h8);
		tick(4);
		chk(temp_lamp_o, 1'b0);
		overtemp_shutdown_strap_i <= 1'b1;
		overtemp_n_i <= 1'b0;
		tick(6);
		chk({supply_inhibit_o, power}, 2'h2);
		overtemp_n_i <= 1'b1;
		tick(6);
		chk(supply_inhibit_o, 1'b1);
		wb(1'b1, STFD_OFS_CTRL, 32'h0);
		wb(1'b1, STFD_OFS_CTRL, 32'h8);
		tick(2);
		chk(supply_inhibit_o, 1'b0);
		$display("overtemperature done");
	endtask : t_hot

	// hang guard, far above the few hundred cycles needed
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 4000) begin
			failures++;
			give_verdict;
		end
	end

	initial begin
		tick(10);
		rst_i <= 1'b0;
		tick(6);
		t_regs;
		t_sums;
		t_self;
		t_lamp;
		t_hot;
		give_verdict;
	end
endmodule : stfd_top_tb
